// ---- common/srq_pkg.sv ----
// Package of constants and carrier structs for the status reporting block
// Contract
// - Calibration bits 1-4 flag failed sensor zeroing
// - Calibration has condition and event parts
// - SRQ when enabled status byte bits 2,3,4,5,7
// - Status byte bits summarise lower sources
// - ESE bit0 gates completion, SRE bit5 summary
// - Operation bit4 measuring, SRE bit7 gates summary
// - Negative transition of measuring latches event
// - Service request is only unsolicited activity
// - Serial poll returns status byte via interface
// - Parallel poll drives only assigned line
// - Poll bit is OR of status AND enable
// - Individual status readable by query
// - Register query returns raw bit pattern
// - Errors queue; read pops; empty gives zero
// - Only reset and preset touch settings
// - Power-on clear and clear-status clear events
// - Only power-on clear clears top enables
// - Power-on clear and preset init transitions
// - Clears halt parser, empty queues
// - Init with pending output logs query interrupted; code logs it on reset, presets, clear-status only
package srq_pkg;
    localparam int SRQ_EQ_DEPTH = 30;
    localparam int SRQ_EQ_AW = 5;
    localparam logic signed [15:0] SRQ_ERR_NONE = 16'sh0000;
    localparam logic signed [15:0] SRQ_ERR_INTERRUPTED = -16'sd410;
    localparam logic signed [15:0] SRQ_ERR_OVERFLOW = -16'sd350;
    localparam int SRQ_STB_EAV = 2;
    localparam int SRQ_STB_QUES = 3;
    localparam int SRQ_STB_MAV = 4;
    localparam int SRQ_STB_ESB = 5;
    localparam int SRQ_STB_RQS = 6;
    localparam int SRQ_STB_OPER = 7;
    localparam int SRQ_ESR_OPC = 0;
    localparam int SRQ_OPER_MEAS = 4;
    localparam logic [7:0] SRQ_SRQ_BITS = 8'hBC;
    localparam logic [15:0] SRQ_CAL_USED = 16'h001E;
    localparam logic [15:0] SRQ_PTR_RESET = 16'h7FFF;
    localparam logic [15:0] SRQ_NTR_RESET = 16'h0000;
    localparam logic [15:0] SRQ_EN_RESET = 16'h0000;

    typedef enum logic [3:0] {
        SRQ_SEL_CAL_COND = 4'h0,
        SRQ_SEL_CAL_EVT = 4'h1,
        SRQ_SEL_OPER_COND = 4'h2,
        SRQ_SEL_OPER_EVT = 4'h3,
        SRQ_SEL_STB = 4'h4,
        SRQ_SEL_ESR = 4'h5,
        SRQ_SEL_SRE = 4'h6,
        SRQ_SEL_ESE = 4'h7,
        SRQ_SEL_PPE = 4'h8,
        SRQ_SEL_IST = 4'h9,
        SRQ_SEL_CAL_EN = 4'hA,
        SRQ_SEL_OPER_EN = 4'hB,
        SRQ_SEL_QUES_COND = 4'hC,
        SRQ_SEL_QUES_EVT = 4'hD,
        SRQ_SEL_QUES_EN = 4'hE
    } srq_sel_e;

    typedef enum logic [3:0] {
        SRQ_WR_NONE = 4'h0,
        SRQ_WR_SRE = 4'h1,
        SRQ_WR_ESE = 4'h2,
        SRQ_WR_PPE = 4'h3,
        SRQ_WR_CAL_EN = 4'h4,
        SRQ_WR_OPER_EN = 4'h5,
        SRQ_WR_OPER_PTR = 4'h6,
        SRQ_WR_OPER_NTR = 4'h7,
        SRQ_WR_CAL_PTR = 4'h8,
        SRQ_WR_CAL_NTR = 4'h9,
        SRQ_WR_QUES_EN = 4'hA,
        SRQ_WR_PSC = 4'hB
    } srq_wr_e;

    typedef struct packed {
        logic power_on;
        logic dev_clear;
        logic rst_cmd;
        logic sys_preset;
        logic stat_preset;
        logic cls;
    } srq_init_s;

    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] evt;
        logic [15:0] en;
        logic [15:0] ptr;
        logic [15:0] ntr;
    } srq_sreg_s;

    typedef struct packed {
        logic signed [15:0] code;
        logic valid;
    } srq_err_s;
endpackage

// ---- verilog/srq_status_reg.sv ----
// One condition/transition/event/enable status register
module srq_status_reg
    import srq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [15:0] cond_i,
    input wire logic [15:0] used_i,
    input wire logic clr_evt_i,
    input wire logic preset_i,
    input wire logic rd_evt_i,
    input wire logic wr_en_i,
    input wire logic wr_ptr_i,
    input wire logic wr_ntr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] cond_o,
    output logic [15:0] evt_o,
    output logic [15:0] en_o,
    output logic summary_o
);
    srq_sreg_s st_reg, st_next;
    logic [15:0] rise, fall, hits;

    always_comb begin
        st_next = st_reg;
        st_next.cond = cond_i & used_i;
        rise = st_next.cond & ~st_reg.cond;
        fall = ~st_next.cond & st_reg.cond;
        hits = (rise & st_reg.ptr) | (fall & st_reg.ntr);
        if (clr_evt_i || rd_evt_i) begin
            st_next.evt = 16'h0000;
        end
        st_next.evt = st_next.evt | hits;
        if (wr_en_i) begin
            st_next.en = wdata_i;
        end
        if (wr_ptr_i) begin
            st_next.ptr = wdata_i;
        end
        if (wr_ntr_i) begin
            st_next.ntr = wdata_i;
        end
        if (preset_i) begin
            st_next.en = SRQ_EN_RESET;
            st_next.ptr = SRQ_PTR_RESET;
            st_next.ntr = SRQ_NTR_RESET;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '{16'h0000, 16'h0000, SRQ_EN_RESET, SRQ_PTR_RESET, SRQ_NTR_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cond_o = st_reg.cond;
    assign evt_o = st_reg.evt;
    assign en_o = st_reg.en;
    assign summary_o = |(st_reg.evt & st_reg.en);
endmodule

// ---- verilog/srq_err_queue.sv ----
// Error queue of 30 entries, first in first out
module srq_err_queue
    import srq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic push_i,
    input wire logic signed [15:0] code_i,
    input wire logic pop_i,
    output srq_err_s head_o,
    output logic nonempty_o
);
    typedef struct packed {
        logic [SRQ_EQ_DEPTH-1:0][15:0] mem;
        logic [SRQ_EQ_AW-1:0] rd;
        logic [SRQ_EQ_AW-1:0] wr;
        logic [SRQ_EQ_AW:0] cnt;
        srq_err_s head;
    } srq_eq_s;

    srq_eq_s q_reg, q_next;

    function automatic logic [SRQ_EQ_AW-1:0] srq_inc(input logic [SRQ_EQ_AW-1:0] p);
        srq_inc = (p == SRQ_EQ_AW'(SRQ_EQ_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        q_next = q_reg;
        q_next.head = '{SRQ_ERR_NONE, 1'b0};
        if (pop_i) begin
            if (q_reg.cnt != '0) begin
                q_next.head = '{q_reg.mem[q_reg.rd], 1'b1};
                q_next.rd = srq_inc(q_reg.rd);
                q_next.cnt = q_reg.cnt - 1'b1;
            end else begin
                q_next.head = '{SRQ_ERR_NONE, 1'b1};
            end
        end
        // Clear before push, so an interrupted-query entry survives clear-status
        if (clr_i) begin
            q_next.rd = '0;
            q_next.wr = '0;
            q_next.cnt = '0;
        end
        if (push_i) begin
            if (q_next.cnt < (SRQ_EQ_AW + 1)'(SRQ_EQ_DEPTH)) begin
                q_next.mem[q_next.wr] = code_i;
                q_next.wr = srq_inc(q_next.wr);
                q_next.cnt = q_next.cnt + 1'b1;
            end else begin
                // Full: newest entry replaced by overflow marker
                q_next.mem[q_next.wr == '0 ? SRQ_EQ_AW'(SRQ_EQ_DEPTH - 1) : q_next.wr - 1'b1] = SRQ_ERR_OVERFLOW;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign head_o = q_reg.head;
    assign nonempty_o = (q_reg.cnt != '0);
endmodule

// ---- verilog/srq_status_top.sv ----
// Status byte, service request, polls and initialization
module srq_status_top
    import srq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] cal_fail_i,
    input wire logic measuring_i,
    input wire logic [15:0] ques_cond_i,
    input wire logic opc_event_i,
    input wire logic [7:0] esr_events_i,
    input wire logic out_avail_i,
    input srq_init_s init_i,
    input wire logic wr_i,
    input srq_wr_e wr_sel_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_i,
    input srq_sel_e rd_sel_i,
    input wire logic err_push_i,
    input wire logic signed [15:0] err_code_i,
    input wire logic err_pop_i,
    input wire logic spoll_i,
    input wire logic ppoll_i,
    input wire logic [2:0] pp_line_i,
    input wire logic pp_sense_i,
    output logic [15:0] rdata_o,
    output srq_err_s err_o,
    output logic srq_o,
    output logic [7:0] spoll_byte_o,
    output logic [7:0] pp_data_o,
    output logic [7:0] pp_oe_n_o,
    output logic out_clear_o,
    output logic parser_halt_o,
    output logic settings_reset_o
);
    typedef struct packed {
        logic [7:0] sre;
        logic [7:0] ese;
        logic [15:0] ppe;
        logic [7:0] esr;
        logic psc;
        logic rqs_sent;
        logic [15:0] rdata;
        logic [7:0] spoll_byte;
        logic [7:0] pp_data;
        logic [7:0] pp_oe_n;
        logic out_clear;
        logic parser_halt;
        logic settings_reset;
    } srq_top_s;

    srq_top_s s_reg, s_next;
    logic pon_clr, evt_clr, preset, rd_cal_evt, rd_oper_evt, rd_ques_evt;
    logic [15:0] cal_cond, cal_evt, cal_en, oper_cond, oper_evt, oper_en;
    logic [15:0] ques_cond, ques_evt, ques_en, ques_in;
    logic cal_sum, oper_sum, ques_sum, eq_nonempty, ist, intr_err;
    logic [7:0] stb;

    function automatic logic srq_rd(input logic rd, input srq_sel_e sel, input srq_sel_e want);
        srq_rd = rd && (sel == want);
    endfunction

    function automatic logic srq_wr(input logic wr, input srq_wr_e sel, input srq_wr_e want);
        srq_wr = wr && (sel == want);
    endfunction

    assign pon_clr = init_i.power_on && s_reg.psc;
    assign evt_clr = pon_clr || init_i.cls;
    assign preset = pon_clr || init_i.stat_preset;
    assign rd_cal_evt = srq_rd(rd_i, rd_sel_i, SRQ_SEL_CAL_EVT);
    assign rd_oper_evt = srq_rd(rd_i, rd_sel_i, SRQ_SEL_OPER_EVT);
    assign rd_ques_evt = srq_rd(rd_i, rd_sel_i, SRQ_SEL_QUES_EVT);
    // Calibration summary folds into questionable bit 8 slot
    assign ques_in = {ques_cond_i[15:9], cal_sum, ques_cond_i[7:0]};
    assign intr_err = out_avail_i && (init_i.rst_cmd || init_i.sys_preset
        || init_i.stat_preset || init_i.cls);

    srq_status_reg u_cal (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i({11'h000, cal_fail_i, 1'b0}),
        .used_i(SRQ_CAL_USED),
        .clr_evt_i(evt_clr),
        .preset_i(preset),
        .rd_evt_i(rd_cal_evt),
        .wr_en_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_CAL_EN)),
        .wr_ptr_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_CAL_PTR)),
        .wr_ntr_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_CAL_NTR)),
        .wdata_i(wdata_i),
        .cond_o(cal_cond),
        .evt_o(cal_evt),
        .en_o(cal_en),
        .summary_o(cal_sum)
    );

    srq_status_reg u_oper (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i({11'h000, measuring_i, 4'h0}),
        .used_i(16'h7FFF),
        .clr_evt_i(evt_clr),
        .preset_i(preset),
        .rd_evt_i(rd_oper_evt),
        .wr_en_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_OPER_EN)),
        .wr_ptr_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_OPER_PTR)),
        .wr_ntr_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_OPER_NTR)),
        .wdata_i(wdata_i),
        .cond_o(oper_cond),
        .evt_o(oper_evt),
        .en_o(oper_en),
        .summary_o(oper_sum)
    );

    srq_status_reg u_ques (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(ques_in),
        .used_i(16'h7FFF),
        .clr_evt_i(evt_clr),
        .preset_i(preset),
        .rd_evt_i(rd_ques_evt),
        .wr_en_i(srq_wr(wr_i, wr_sel_i, SRQ_WR_QUES_EN)),
        .wr_ptr_i(1'b0),
        .wr_ntr_i(1'b0),
        .wdata_i(wdata_i),
        .cond_o(ques_cond),
        .evt_o(ques_evt),
        .en_o(ques_en),
        .summary_o(ques_sum)
    );

    srq_err_queue u_eq (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clr_i(init_i.power_on || init_i.cls),
        .push_i(err_push_i || intr_err),
        .code_i(intr_err ? SRQ_ERR_INTERRUPTED : err_code_i),
        .pop_i(err_pop_i),
        .head_o(err_o),
        .nonempty_o(eq_nonempty)
    );

    // Status byte: lower summaries, queue, output buffer
    always_comb begin
        stb = 8'h00;
        stb[SRQ_STB_EAV] = eq_nonempty;
        stb[SRQ_STB_QUES] = ques_sum;
        stb[SRQ_STB_MAV] = out_avail_i;
        stb[SRQ_STB_ESB] = |(s_reg.esr & s_reg.ese);
        stb[SRQ_STB_OPER] = oper_sum;
        stb[SRQ_STB_RQS] = |(stb & s_reg.sre & SRQ_SRQ_BITS);
    end

    assign ist = |({8'h00, stb} & s_reg.ppe);

    always_comb begin
        s_next = s_reg;
        s_next.out_clear = init_i.power_on || init_i.dev_clear;
        s_next.parser_halt = init_i.power_on || init_i.dev_clear;
        s_next.settings_reset = init_i.rst_cmd || init_i.sys_preset;
        s_next.esr = s_reg.esr;
        if (srq_rd(rd_i, rd_sel_i, SRQ_SEL_ESR) || evt_clr) begin
            s_next.esr = 8'h00;
        end
        // Set wins over clear on the same cycle
        s_next.esr = s_next.esr | esr_events_i;
        s_next.esr[SRQ_ESR_OPC] = s_next.esr[SRQ_ESR_OPC] | opc_event_i;
        if (wr_i) begin
            unique case (wr_sel_i)
                SRQ_WR_SRE: s_next.sre = wdata_i[7:0];
                SRQ_WR_ESE: s_next.ese = wdata_i[7:0];
                SRQ_WR_PPE: s_next.ppe = wdata_i;
                SRQ_WR_PSC: s_next.psc = wdata_i[0];
                default: s_next.psc = s_reg.psc;
            endcase
        end
        if (pon_clr) begin
            s_next.sre = 8'h00;
            s_next.ese = 8'h00;
            s_next.ppe = 16'h0000;
        end
        if (rd_i) begin
            unique case (rd_sel_i)
                SRQ_SEL_CAL_COND: s_next.rdata = cal_cond;
                SRQ_SEL_CAL_EVT: s_next.rdata = cal_evt;
                SRQ_SEL_OPER_COND: s_next.rdata = oper_cond;
                SRQ_SEL_OPER_EVT: s_next.rdata = oper_evt;
                SRQ_SEL_STB: s_next.rdata = {8'h00, stb};
                SRQ_SEL_ESR: s_next.rdata = {8'h00, s_reg.esr};
                SRQ_SEL_SRE: s_next.rdata = {8'h00, s_reg.sre};
                SRQ_SEL_ESE: s_next.rdata = {8'h00, s_reg.ese};
                SRQ_SEL_PPE: s_next.rdata = s_reg.ppe;
                SRQ_SEL_IST: s_next.rdata = {15'h0000, ist};
                SRQ_SEL_CAL_EN: s_next.rdata = cal_en;
                SRQ_SEL_OPER_EN: s_next.rdata = oper_en;
                SRQ_SEL_QUES_COND: s_next.rdata = ques_cond;
                SRQ_SEL_QUES_EVT: s_next.rdata = ques_evt;
                SRQ_SEL_QUES_EN: s_next.rdata = ques_en;
                default: s_next.rdata = 16'h0000;
            endcase
        end
        // Serial poll answers over interface messages, clearing request
        if (spoll_i) begin
            s_next.spoll_byte = {stb[7], stb[6] & ~s_reg.rqs_sent, stb[5:0]};
            s_next.rqs_sent = stb[SRQ_STB_RQS];
        end else if (!stb[SRQ_STB_RQS]) begin
            s_next.rqs_sent = 1'b0;
        end
        // Parallel poll drives its one line only
        s_next.pp_data = 8'h00;
        s_next.pp_oe_n = 8'hFF;
        if (ppoll_i) begin
            s_next.pp_data[pp_line_i] = ist ^ ~pp_sense_i;
            s_next.pp_oe_n[pp_line_i] = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '{8'h00, 8'h00, 16'h0000, 8'h00, 1'b1, 1'b0, 16'h0000,
                8'h00, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Request line is the only unsolicited output
    assign srq_o = stb[SRQ_STB_RQS] && !s_reg.rqs_sent;
    assign rdata_o = s_reg.rdata;
    assign spoll_byte_o = s_reg.spoll_byte;
    assign pp_data_o = s_reg.pp_data;
    assign pp_oe_n_o = s_reg.pp_oe_n;
    assign out_clear_o = s_reg.out_clear;
    assign parser_halt_o = s_reg.parser_halt;
    assign settings_reset_o = s_reg.settings_reset;
endmodule

// ---- sim/srq_status_properties.sv ----
// Checker of poll, clear, error and read answers at the status block ports
module srq_status_properties
    import srq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] cal_fail_i,
    input srq_init_s init_i,
    input wire logic rd_i,
    input srq_sel_e rd_sel_i,
    input wire logic err_pop_i,
    input wire logic spoll_i,
    input wire logic ppoll_i,
    input wire logic [2:0] pp_line_i,
    input wire logic [15:0] rdata_o,
    input srq_err_s err_o,
    input wire logic srq_o,
    input wire logic [7:0] spoll_byte_o,
    input wire logic [7:0] pp_oe_n_o,
    input wire logic out_clear_o,
    input wire logic parser_halt_o,
    input wire logic settings_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_clear_req;
        init_i.power_on || init_i.dev_clear;
    endsequence

    a_pp_line: assert property (ppoll_i |=> pp_oe_n_o == ~(8'h01 << $past(pp_line_i)))
        else $error("parallel poll drove a wrong line");
    a_pp_idle: assert property (!ppoll_i |=> pp_oe_n_o == 8'hFF)
        else $error("poll line driven outside a poll");
    a_spoll_rqs: assert property (spoll_i && srq_o |=> spoll_byte_o[6] && !srq_o)
        else $error("serial poll did not report and drop the request");
    a_err_answer: assert property (err_pop_i |=> err_o.valid)
        else $error("error read gave no answer");
    a_err_quiet: assert property (!err_pop_i |=> !err_o.valid)
        else $error("error answer without a read");
    a_clear_halt: assert property (s_clear_req |=> parser_halt_o && out_clear_o)
        else $error("clear did not halt parser and empty output");
    a_halt_quiet: assert property (!(init_i.power_on || init_i.dev_clear) |=> !parser_halt_o)
        else $error("parser halted without a clear");
    a_settings_set: assert property (init_i.rst_cmd || init_i.sys_preset |=> settings_reset_o)
        else $error("reset or preset left settings alone");
    a_settings_quiet: assert property (!(init_i.rst_cmd || init_i.sys_preset) |=> !settings_reset_o)
        else $error("settings touched by another event");
    a_cal_cond: assert property (rd_i && rd_sel_i == SRQ_SEL_CAL_COND && $stable(cal_fail_i)
        |=> rdata_o == {11'h000, $past(cal_fail_i), 1'b0})
        else $error("calibration condition pattern wrong");
    a_unmapped_zero: assert property (rd_i && rd_sel_i == srq_sel_e'(4'hF) |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind srq_status_top srq_status_properties chk_u (.mclk_i, .rst_i, .cal_fail_i, .init_i, .rd_i, .rd_sel_i,
    .err_pop_i, .spoll_i, .ppoll_i, .pp_line_i, .rdata_o, .err_o, .srq_o, .spoll_byte_o, .pp_oe_n_o,
    .out_clear_o, .parser_halt_o, .settings_reset_o);

// ---- sim/srq_ctrl_model.sv ----
// Bus controller model that answers service requests with a serial poll
module srq_ctrl_model
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic srq_i,
    input wire logic auto_i,
    output logic spoll_o,
    output int polls_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spoll_o = 1'b0;
        polls_o = 0;
    end
    // Never polls back to back, so one request gets one poll
    always @(posedge mclk_i) begin
        #2;
        spoll_o = !rst_i && auto_i && srq_i && !spoll_o;
        if (spoll_o) begin
            polls_o++;
        end
    end
endmodule

// ---- sim/tb_status_reporting_srq_poll.sv ----
// Testbench of the status reporting block
module tb_status_reporting_srq_poll import srq_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] cal_fail_i;
    logic measuring_i, opc_event_i, out_avail_i, wr_i, rd_i, err_push_i, err_pop_i, tb_spoll, ppoll_i;
    logic pp_sense_i, auto_poll, mdl_spoll, srq_o, out_clear_o, parser_halt_o, settings_reset_o;
    logic [15:0] ques_cond_i, wdata_i, rdata_o;
    logic signed [15:0] err_code_i;
    logic [7:0] esr_events_i, spoll_byte_o, pp_data_o, pp_oe_n_o;
    logic [2:0] pp_line_i;
    srq_init_s init_i;
    srq_wr_e wr_sel_i;
    srq_sel_e rd_sel_i;
    srq_err_s err_o;
    wire logic spoll_i;
    int polls, mismatches, checks_done;
    assign spoll_i = tb_spoll | mdl_spoll;

    srq_status_top dut_u (.mclk_i, .rst_i, .cal_fail_i, .measuring_i, .ques_cond_i, .opc_event_i,
        .esr_events_i, .out_avail_i, .init_i, .wr_i, .wr_sel_i, .wdata_i, .rd_i, .rd_sel_i, .err_push_i,
        .err_code_i, .err_pop_i, .spoll_i, .ppoll_i, .pp_line_i, .pp_sense_i, .rdata_o, .err_o, .srq_o,
        .spoll_byte_o, .pp_data_o, .pp_oe_n_o, .out_clear_o, .parser_halt_o, .settings_reset_o);
    srq_ctrl_model mdl_u (.mclk_i, .rst_i, .srq_i(srq_o), .auto_i(auto_poll), .spoll_o(mdl_spoll),
        .polls_o(polls));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic step(int n = 1);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes drop for a cycle between calls, so no signal is set twice at once
    task automatic wr(srq_wr_e sel, logic [15:0] d);
        wr_i = 1'b1;
        wr_sel_i = sel;
        wdata_i = d;
        step();
        wr_i = 1'b0;
        step();
    endtask
    task automatic rd(srq_sel_e sel, logic [15:0] exp);
        rd_i = 1'b1;
        rd_sel_i = sel;
        step();
        rd_i = 1'b0;
        check(rdata_o, exp);
        step();
    endtask
    task automatic init_pulse(logic [5:0] v, logic [1:0] exp);
        init_i = v;
        step();
        init_i = '0;
        check({14'h0000, parser_halt_o, settings_reset_o}, {14'h0000, exp});
        step();
    endtask
    task automatic push(logic [15:0] c);
        err_push_i = 1'b1;
        err_code_i = c;
        step();
        err_push_i = 1'b0;
        step();
    endtask
    task automatic pop(logic [15:0] exp);
        err_pop_i = 1'b1;
        step();
        err_pop_i = 1'b0;
        check(err_o.code, exp);
        check({15'h0000, err_o.valid}, 16'h0001);
        step();
    endtask
    task automatic wait_srq(logic e);
        for (int i = 0; i < 8 && srq_o !== e; i++) step();
        check({15'h0000, srq_o}, {15'h0000, e});
    endtask
    task automatic ppoll(logic [2:0] l, logic s, logic ist);
        pp_line_i = l;
        pp_sense_i = s;
        ppoll_i = 1'b1;
        step();
        ppoll_i = 1'b0;
        check({8'h00, pp_oe_n_o}, {8'h00, ~(8'h01 << l)});
        check({15'h0000, pp_data_o[l]}, {15'h0000, ~(ist ^ s)});
        step();
    endtask

    task automatic t_reset;
        rd(SRQ_SEL_SRE, 16'h0000);
        rd(SRQ_SEL_PPE, 16'h0000);
        rd(SRQ_SEL_CAL_EN, 16'h0000);
        rd(srq_sel_e'(4'hF), 16'h0000);
        check({8'h00, pp_oe_n_o}, 16'h00FF);
        $display("test reset done");
    endtask
    task automatic t_cal;
        cal_fail_i = 4'hA;
        step(2);
        rd(SRQ_SEL_CAL_COND, 16'h0014);
        rd(SRQ_SEL_CAL_EVT, 16'h0014);
        rd(SRQ_SEL_CAL_EVT, 16'h0000);
        cal_fail_i = 4'h5;
        step(2);
        rd(SRQ_SEL_CAL_COND, 16'h000A);
        cal_fail_i = 4'h0;
        $display("test calibration done");
    endtask
    task automatic t_opc;
        auto_poll = 1'b1;
        wr(SRQ_WR_ESE, 16'h0001);
        wr(SRQ_WR_SRE, 16'h0020);
        opc_event_i = 1'b1;
        step();
        opc_event_i = 1'b0;
        for (int i = 0; i < 10 && polls == 0; i++) step();
        step();
        check(16'(polls), 16'h0001);
        check({8'h00, spoll_byte_o & 8'h60}, 16'h0060);
        auto_poll = 1'b0;
        init_pulse(6'h01, 2'h0);
        rd(SRQ_SEL_ESR, 16'h0000);
        rd(SRQ_SEL_SRE, 16'h0020);
        $display("test completion request done");
    endtask
    task automatic t_meas;
        wr(SRQ_WR_SRE, 16'h0080);
        wr(SRQ_WR_OPER_PTR, 16'h0000);
        wr(SRQ_WR_OPER_NTR, 16'h0010);
        wr(SRQ_WR_OPER_EN, 16'h0010);
        measuring_i = 1'b1;
        step(4);
        check({15'h0000, srq_o}, 16'h0000);
        measuring_i = 1'b0;
        wait_srq(1'b1);
        rd(SRQ_SEL_OPER_EVT, 16'h0010);
        wait_srq(1'b0);
        $display("test measurement end done");
    endtask
    task automatic t_ppoll;
        wr(SRQ_WR_SRE, 16'h0010);
        wr(SRQ_WR_PPE, 16'h0010);
        out_avail_i = 1'b1;
        wait_srq(1'b1);
        tb_spoll = 1'b1;
        step();
        tb_spoll = 1'b0;
        check({8'h00, spoll_byte_o}, 16'h0050);
        check({15'h0000, srq_o}, 16'h0000);
        rd(SRQ_SEL_IST, 16'h0001);
        ppoll(3'h5, 1'b1, 1'b1);
        ppoll(3'h2, 1'b0, 1'b1);
        wr(SRQ_WR_PPE, 16'h0000);
        rd(SRQ_SEL_IST, 16'h0000);
        ppoll(3'h7, 1'b1, 1'b0);
        ppoll(3'h0, 1'b0, 1'b0);
        init_pulse(6'h08, 2'h1);
        out_avail_i = 1'b0;
        pop(SRQ_ERR_INTERRUPTED);
        pop(SRQ_ERR_NONE);
        $display("test parallel poll done");
    endtask
    task automatic t_errq;
        for (int i = 1; i <= 31; i++) push(16'(-i));
        rd(SRQ_SEL_STB, 16'h0004);
        for (int i = 1; i <= 29; i++) pop(16'(-i));
        pop(SRQ_ERR_OVERFLOW);
        pop(SRQ_ERR_NONE);
        push(16'(-7));
        init_pulse(6'h01, 2'h0);
        pop(SRQ_ERR_NONE);
        out_avail_i = 1'b1;
        init_pulse(6'h01, 2'h0);
        out_avail_i = 1'b0;
        pop(SRQ_ERR_INTERRUPTED);
        $display("test error queue done");
    endtask
    task automatic t_init;
        wr(SRQ_WR_ESE, 16'h0001);
        wr(SRQ_WR_PPE, 16'h0010);
        wr(SRQ_WR_CAL_EN, 16'h001E);
        init_pulse(6'h10, 2'h2);
        rd(SRQ_SEL_SRE, 16'h0010);
        init_pulse(6'h02, 2'h0);
        rd(SRQ_SEL_CAL_EN, 16'h0000);
        rd(SRQ_SEL_PPE, 16'h0010);
        wr(SRQ_WR_CAL_EN, 16'h001E);
        wr(SRQ_WR_PSC, 16'h0000);
        init_pulse(6'h20, 2'h2);
        rd(SRQ_SEL_SRE, 16'h0010);
        rd(SRQ_SEL_CAL_EN, 16'h001E);
        wr(SRQ_WR_PSC, 16'h0001);
        init_pulse(6'h20, 2'h2);
        rd(SRQ_SEL_SRE, 16'h0000);
        rd(SRQ_SEL_ESE, 16'h0000);
        rd(SRQ_SEL_PPE, 16'h0000);
        rd(SRQ_SEL_CAL_EN, 16'h0000);
        init_pulse(6'h04, 2'h1);
        $display("test initialization done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial begin
        #(25 * 20000);
        mismatches++;
        conclude();
    end

    initial begin
        {cal_fail_i, measuring_i, opc_event_i, out_avail_i, wr_i, rd_i, err_push_i, err_pop_i} = '0;
        {tb_spoll, ppoll_i, pp_sense_i, auto_poll, ques_cond_i, wdata_i, err_code_i} = '0;
        {esr_events_i, pp_line_i} = '0;
        init_i = '0;
        wr_sel_i = SRQ_WR_NONE;
        rd_sel_i = SRQ_SEL_CAL_COND;
        repeat (20) @(posedge mclk_i);
        #2;
        rst_i = 1'b0;
        step();
        t_reset();
        t_cal();
        t_opc();
        t_meas();
        t_ppoll();
        t_errq();
        t_init();
        conclude();
    end
endmodule
